// ### design/essb_pkg.sv
// constants and types for the egress shaper and vlan tagger
`default_nettype none
package essb_pkg;
   // sizes
   localparam int NPORT = 3;
   localparam int NQ = 4;
   localparam int NBKT = 12;
   localparam int RATE_W = 13;
   localparam int LEN_W = 11;
   localparam int CNT_W = 27;
   localparam int CFG_W = 6;
   localparam int VID_W = 15;
   localparam int DCNT_W = 32;

   // timing: rate setting steps of 20 ns, clock 5 ns
   localparam int CLK_NS = 5;
   localparam int RATE_STEP_NS = 20;
   localparam int STEP_CYC = RATE_STEP_NS / CLK_NS;
   localparam logic [RATE_W-1:0] RATE_FLOOR = 13'h0003;
   localparam logic [RATE_W-1:0] RATE_10M_MAX = 13'h0027;

   // register byte offsets
   localparam logic [7:0] REG_TAG_CFG = 8'h00;
   localparam logic [7:0] REG_RATE_EN = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_DEF_VID0 = 8'h20;
   localparam logic [7:0] REG_RATE0 = 8'h40;
   localparam logic [7:0] REG_TOT_DROP0 = 8'h80;
   localparam logic [7:0] REG_RATE_DROP0 = 8'h90;

   // reset values
   localparam logic [NPORT*CFG_W-1:0] TAG_CFG_RST = 18'h00000;
   localparam logic [VID_W-1:0] DEF_VID_RST = 15'h0001;
   localparam logic [RATE_W-1:0] RATE_RST = 13'h0000;
   localparam logic [NBKT-1:0] RATE_EN_RST = 12'h000;

   typedef enum logic [1:0] {
      ESSB_DUMB   = 2'h0,
      ESSB_ACCESS = 2'h1,
      ESSB_HYBRID = 2'h2,
      ESSB_CPU    = 2'h3
   } essb_egr_t;

   typedef enum logic [1:0] {
      ESSB_UNTAGGED = 2'h0,
      ESSB_PRIO_TAG = 2'h1,
      ESSB_NORM_TAG = 2'h2,
      ESSB_SPEC_TAG = 2'h3
   } essb_rx_t;

   // egress_port_tag_config field layout, one per port
   typedef struct packed {
      logic      chg_prio;
      logic      chg_vid;
      logic      chg_tag;
      logic      ins_tag;
      essb_egr_t egr;
   } essb_port_cfg_t;

   // portN_default_vid_prio layout
   typedef struct packed {
      logic [2:0]  prio;
      logic [11:0] vlan_identifier;
   } essb_vid_t;

   typedef struct packed {
      logic        vld;
      logic [1:0]  src;
      logic [1:0]  dst;
      essb_rx_t    kind;
      logic [11:0] vlan_identifier;
      logic [2:0]  prio;
      logic [2:0]  untag_vid;
      logic [2:0]  untag_def;
   } essb_pkt_t;

   typedef struct packed {
      logic        vld;
      logic        strip;
      logic        insert;
      logic        special;
      logic        rewrite;
      logic        fcs_regen;
      logic [11:0] vlan_identifier;
      logic [2:0]  prio;
   } essb_tag_t;

   typedef struct packed {
      logic       vld;
      logic [1:0] src;
      logic       rate;
   } essb_drop_t;
endpackage : essb_pkg
`default_nettype wire

// ### design/essb_top.sv
// egress rate limiter, vlan tag decision, drop counters and register slave
//
// How it works
// - every port queue has its own leaky bucket, enabled per queue.
// - a queue over its rate is simply not served; packets wait in memory.
// - limiter eligibility masks queues before priority selection, so lower queues run.
// - on selection, block the queue for head length times per-byte time.
// - rate setting means per-byte delay in 20 ns steps.
// - settings 0 to 3 give 80 ns; larger give (setting+1) times 20 ns.
// - on a 10 Mbps port settings above 39 disable the limiter.
// - packets come in four tag kinds; egress ports have four types.
// - dumb ports pass tags; dumb, access, hybrid and cpu all strip an incoming special tag.
// - access ports pass untagged packets and strip priority or normal tags.
// - cpu type egress ports insert the special source port tag.
// - un-tag bit is chosen by ingress port from the looked-up table entry.
// - hybrid untagged: insert ingress default tag if insert set and un-tag clear.
// - hybrid priority tag: strip on un-tag, else set vid, maybe priority.
// - hybrid normal tag: strip, pass, or replace fields with egress defaults.
// - each of three ports has programmable default vid and priority.
// - per source port, count buffer drops plus ingress rate drops.
// - per source port, count ingress rate drops alone.
// - drop events raise sticky interrupt bits, each maskable.
// - special tag carries source port in vid bits 0 and 1, inner tag kept.
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module essb_top (
   // clock and reset
   input  wire logic                                        i_clk,
   input  wire logic                                        i_rst,
   // avalon-mm slave
   input  wire logic [7:0]                                  i_avs_address,
   input  wire logic                                        i_avs_read,
   input  wire logic                                        i_avs_write,
   input  wire logic [31:0]                                 i_avs_writedata,
   input  wire logic [3:0]                                  i_avs_byteenable,
   output logic      [31:0]                                 o_avs_readdata,
   output logic                                             o_avs_waitrequest,
   // queue state from the packet buffer
   input  wire logic [essb_pkg::NBKT-1:0]                   i_q_nonempty,
   input  wire logic [essb_pkg::NBKT-1:0][essb_pkg::LEN_W-1:0] i_q_head_len,
   // transmit mac side
   input  wire logic [essb_pkg::NPORT-1:0]                  i_tx_req,
   input  wire logic [essb_pkg::NPORT-1:0]                  i_port_10m,
   output logic      [essb_pkg::NPORT-1:0]                  o_grant_vld,
   output logic      [essb_pkg::NPORT-1:0][1:0]             o_grant_q,
   output logic      [essb_pkg::NBKT-1:0]                   o_q_blocked,
   // tag decision
   input  wire essb_pkg::essb_pkt_t                         i_pkt,
   output essb_pkg::essb_tag_t                              o_tag,
   // drop reports and interrupt
   input  wire essb_pkg::essb_drop_t                        i_drop,
   output logic                                             o_irq
);

   localparam int NP = essb_pkg::NPORT;
   localparam int NB = essb_pkg::NBKT;

   // registers
   essb_pkg::essb_port_cfg_t [NP-1:0]               cfg_r;
   essb_pkg::essb_vid_t      [NP-1:0]               def_r;
   logic [NB-1:0][essb_pkg::RATE_W-1:0]             rate_r;
   logic [NB-1:0]                                   rate_en_r;
   logic [NP-1:0][essb_pkg::DCNT_W-1:0]             tot_cnt_r;
   logic [NP-1:0][essb_pkg::DCNT_W-1:0]             rate_cnt_r;
   logic [NP-1:0]                                   irq_stat_r;
   logic [NP-1:0]                                   irq_mask_r;
   logic                                            ack_r;

   // bus helpers
   logic [7:0]  a;
   logic        wr;
   logic [31:0] rd_mux;
   logic [31:0] bmask;
   logic [31:0] wval;
   logic [2:0]  def_h;
   logic [2:0]  tot_h;
   logic [2:0]  rdp_h;

   // shaper helpers
   logic [NB-1:0]        elig;
   logic [NB-1:0]        take;
   logic [NP-1:0]        fire;
   logic [NP-1:0][1:0]   sel_q;
   logic [NP-1:0]        drop_ev;
   essb_pkg::essb_tag_t  tag_nxt;

   // hit and index for a group of three per-port words
   function automatic logic [2:0] port_hit(input logic [7:0] ad, input logic [7:0] base);
      logic hit;
      hit = (ad[7:4] == base[7:4]) && (ad[3:2] < 2'(NP)) && (ad[1:0] == 2'h0);
      return {hit, ad[3:2]};
   endfunction : port_hit

   function automatic logic rate_hit(input logic [7:0] ad);
      return (ad[7:6] == essb_pkg::REG_RATE0[7:6]) && (ad[5:2] < 4'(NB)) && (ad[1:0] == 2'h0);
   endfunction : rate_hit

   // per-byte hold in clock cycles
   function automatic logic [15:0] byte_cyc(input logic [essb_pkg::RATE_W-1:0] s);
      logic [15:0] e;
      e = {3'h0, (s < essb_pkg::RATE_FLOOR) ? essb_pkg::RATE_FLOOR : s} + 16'h0001;
      return 16'(e * essb_pkg::STEP_CYC);
   endfunction : byte_cyc

   // highest non-empty eligible queue wins
   function automatic logic [2:0] pick_hi(input logic [essb_pkg::NQ-1:0] c);
      logic [2:0] r;
      r = 3'h0;
      for (int q = 0; q < essb_pkg::NQ; q++) begin
         if (c[q]) begin
            r = {1'b1, 2'(q)};
         end
      end
      return r;
   endfunction : pick_hi

   // avalon slave: one wait state, read data captured on the first cycle
   assign a = i_avs_address;
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
   assign wr = i_avs_write & ack_r;
   assign def_h = port_hit(a, essb_pkg::REG_DEF_VID0);
   assign tot_h = port_hit(a, essb_pkg::REG_TOT_DROP0);
   assign rdp_h = port_hit(a, essb_pkg::REG_RATE_DROP0);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      if (a == essb_pkg::REG_TAG_CFG) begin
         rd_mux = 32'(cfg_r);
      end else if (a == essb_pkg::REG_RATE_EN) begin
         rd_mux = 32'(rate_en_r);
      end else if (a == essb_pkg::REG_IRQ_STAT) begin
         rd_mux = 32'(irq_stat_r);
      end else if (a == essb_pkg::REG_IRQ_MASK) begin
         rd_mux = 32'(irq_mask_r);
      end else if (rate_hit(a)) begin
         rd_mux = 32'(rate_r[a[5:2]]);
      end else if (def_h[2]) begin
         rd_mux = 32'(def_r[def_h[1:0]]);
      end else if (tot_h[2]) begin
         rd_mux = tot_cnt_r[tot_h[1:0]];
      end else if (rdp_h[2]) begin
         rd_mux = rate_cnt_r[rdp_h[1:0]];
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         bmask[8*i +: 8] = {8{i_avs_byteenable[i]}};
      end
   end

   assign wval = (rd_mux & ~bmask) | (i_avs_writedata & bmask);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_avs_readdata <= 32'h0;
      end else if (i_avs_read & ~ack_r) begin
         o_avs_readdata <= rd_mux;
      end
   end

   // configuration writes
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cfg_r <= essb_pkg::TAG_CFG_RST;
      end else if (wr && a == essb_pkg::REG_TAG_CFG) begin
         cfg_r <= wval[NP*essb_pkg::CFG_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         def_r <= {NP{essb_pkg::DEF_VID_RST}};
      end else if (wr && def_h[2]) begin
         def_r[def_h[1:0]] <= wval[essb_pkg::VID_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rate_en_r <= essb_pkg::RATE_EN_RST;
         rate_r <= {NB{essb_pkg::RATE_RST}};
      end else if (wr && a == essb_pkg::REG_RATE_EN) begin
         rate_en_r <= wval[NB-1:0];
      end else if (wr && rate_hit(a)) begin
         rate_r[a[5:2]] <= wval[essb_pkg::RATE_W-1:0];
      end
   end

   // leaky buckets, one per port queue
   for (genvar b = 0; b < NB; b++) begin : g_bkt
      logic [essb_pkg::CNT_W-1:0] cnt_r;
      logic                       lim;
      assign lim = rate_en_r[b]
                 & ~(i_port_10m[b/essb_pkg::NQ] & (rate_r[b] > essb_pkg::RATE_10M_MAX));
      assign elig[b] = ~lim | (cnt_r == '0);
      assign take[b] = fire[b/essb_pkg::NQ] & (sel_q[b/essb_pkg::NQ] == 2'(b % essb_pkg::NQ));
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            cnt_r <= '0;
         end else if (take[b] & lim) begin
            cnt_r <= essb_pkg::CNT_W'(i_q_head_len[b])
                   * essb_pkg::CNT_W'(byte_cyc(rate_r[b]));
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   assign o_q_blocked = ~elig;

   // per port selection among eligible queues
   for (genvar p = 0; p < NP; p++) begin : g_port
      logic [essb_pkg::NQ-1:0] cand;
      logic [2:0]              pk;
      assign cand = i_q_nonempty[p*essb_pkg::NQ +: essb_pkg::NQ]
                  & elig[p*essb_pkg::NQ +: essb_pkg::NQ];
      assign pk = pick_hi(cand);
      assign sel_q[p] = pk[1:0];
      assign fire[p] = i_tx_req[p] & ~o_grant_vld[p] & pk[2];
      assign drop_ev[p] = i_drop.vld & (i_drop.src == 2'(p));
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_grant_vld <= '0;
         o_grant_q <= '0;
      end else begin
         o_grant_vld <= fire;
         for (int p = 0; p < NP; p++) begin
            if (fire[p]) begin
               o_grant_q[p] <= sel_q[p];
            end
         end
      end
   end

   // tag decision for the egress packet
   always_comb begin
      essb_pkg::essb_port_cfg_t ec;
      essb_pkg::essb_vid_t      di;
      essb_pkg::essb_vid_t      de;
      logic                     ud;
      logic                     up;
      ec = cfg_r[i_pkt.dst];
      di = def_r[i_pkt.src];
      de = def_r[i_pkt.dst];
      ud = i_pkt.untag_def[i_pkt.src];
      up = i_pkt.untag_vid[i_pkt.src];
      tag_nxt = '0;
      tag_nxt.vld = i_pkt.vld;
      tag_nxt.vlan_identifier = i_pkt.vlan_identifier;
      tag_nxt.prio = i_pkt.prio;
      tag_nxt.strip = (i_pkt.kind == essb_pkg::ESSB_SPEC_TAG);
      unique case (ec.egr)
         essb_pkg::ESSB_CPU: begin
            tag_nxt.insert = 1'b1;
            tag_nxt.special = 1'b1;
            tag_nxt.vlan_identifier = {10'h000, i_pkt.src};
         end
         essb_pkg::ESSB_ACCESS: begin
            if (i_pkt.kind == essb_pkg::ESSB_PRIO_TAG || i_pkt.kind == essb_pkg::ESSB_NORM_TAG) begin
               tag_nxt.strip = 1'b1;
            end
         end
         essb_pkg::ESSB_HYBRID: begin
            unique case (i_pkt.kind)
               essb_pkg::ESSB_UNTAGGED: begin
                  tag_nxt.insert = ec.ins_tag & ~ud;
                  tag_nxt.vlan_identifier = di.vlan_identifier;
                  tag_nxt.prio = di.prio;
               end
               essb_pkg::ESSB_PRIO_TAG: begin
                  tag_nxt.strip = ud;
                  tag_nxt.rewrite = ~ud;
                  tag_nxt.vlan_identifier = di.vlan_identifier;
                  tag_nxt.prio = ec.chg_prio ? di.prio : i_pkt.prio;
               end
               essb_pkg::ESSB_NORM_TAG: begin
                  if (up) begin
                     tag_nxt.strip = 1'b1;
                  end else if (ec.chg_tag && (ec.chg_vid || ec.chg_prio)) begin
                     tag_nxt.rewrite = 1'b1;
                     tag_nxt.vlan_identifier = ec.chg_vid ? de.vlan_identifier : i_pkt.vlan_identifier;
                     tag_nxt.prio = ec.chg_prio ? de.prio : i_pkt.prio;
                  end
               end
               essb_pkg::ESSB_SPEC_TAG: begin
               end
            endcase
         end
         essb_pkg::ESSB_DUMB: begin
         end
      endcase
      tag_nxt.fcs_regen = tag_nxt.strip | tag_nxt.insert | tag_nxt.rewrite;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_tag <= '0;
      end else begin
         o_tag <= tag_nxt;
      end
   end

   // drop counters per source port
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tot_cnt_r <= '0;
         rate_cnt_r <= '0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            if (drop_ev[p]) begin
               tot_cnt_r[p] <= tot_cnt_r[p] + 1'b1;
               if (i_drop.rate) begin
                  rate_cnt_r[p] <= rate_cnt_r[p] + 1'b1;
               end
            end
         end
      end
   end

   // interrupt status: write one to clear, a new event wins over the clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_stat_r <= '0;
      end else if (wr && a == essb_pkg::REG_IRQ_STAT) begin
         irq_stat_r <= (irq_stat_r & ~wval[NP-1:0] | ~bmask[NP-1:0] & irq_stat_r) | drop_ev;
      end else begin
         irq_stat_r <= irq_stat_r | drop_ev;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_mask_r <= '0;
      end else if (wr && a == essb_pkg::REG_IRQ_MASK) begin
         irq_mask_r <= wval[NP-1:0];
      end
   end

   assign o_irq = |(irq_stat_r & irq_mask_r);

endmodule : essb_top
`default_nettype wire

// ### testbench/essb_chk.sv
// concurrent checks on the egress shaper top ports
`timescale 1ns/10ps
`default_nettype none
module essb_chk (
   // clock and reset
   input wire logic                            i_clk,
   input wire logic                            i_rst,
   // register bus
   input wire logic [7:0]                      i_avs_address,
   input wire logic                            i_avs_read,
   input wire logic                            i_avs_write,
   input wire logic [31:0]                     o_avs_readdata,
   input wire logic                            o_avs_waitrequest,
   // scheduler
   input wire logic [essb_pkg::NBKT-1:0]       i_q_nonempty,
   input wire logic [essb_pkg::NPORT-1:0]      i_tx_req,
   input wire logic [essb_pkg::NPORT-1:0]      o_grant_vld,
   input wire logic [essb_pkg::NPORT-1:0][1:0] o_grant_q,
   input wire logic [essb_pkg::NBKT-1:0]       o_q_blocked,
   // tagger
   input wire essb_pkg::essb_pkt_t             i_pkt,
   input wire essb_pkg::essb_tag_t             o_tag
);
   logic [11:0]         elig_r;
   logic [2:0]          req_r;
   logic                rst_r;
   essb_pkg::essb_pkt_t pkt_r;
   always_ff @(posedge i_clk) begin
      elig_r <= i_q_nonempty & ~o_q_blocked;
      req_r  <= i_tx_req;
      rst_r  <= i_rst;
      pkt_r  <= i_pkt;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_wait_once: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("more than one wait state");
   a_wait_idle: assert property (!(i_avs_read | i_avs_write) |-> !o_avs_waitrequest)
      else $error("waitrequest without request");
   a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
      && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0) else $error("misaligned read");
   a_grant_gap: assert property ((o_grant_vld & $past(o_grant_vld)) == 3'h0)
      else $error("grants in consecutive cycles");
   for (genvar p = 0; p < 3; p++) begin : g_port
      a_grant_cause: assert property (!rst_r && o_grant_vld[p] |-> req_r[p]
         && (elig_r[p*4 +: 4] >> o_grant_q[p]) == 4'h1) else $error("grant not top eligible");
   end
   a_tag_follow: assert property (!rst_r |-> o_tag.vld == pkt_r.vld)
      else $error("tag decision not one cycle after packet");
   a_fcs_regen: assert property (o_tag.vld |-> o_tag.fcs_regen ==
      (o_tag.strip | o_tag.insert | o_tag.rewrite)) else $error("crc request mismatch");
   a_spec_strip: assert property (!rst_r && pkt_r.vld
      && pkt_r.kind == essb_pkg::ESSB_SPEC_TAG |-> o_tag.strip) else $error("special kept");
   a_untag_keep: assert property (!rst_r && pkt_r.vld
      && pkt_r.kind == essb_pkg::ESSB_UNTAGGED |-> !o_tag.strip && !o_tag.rewrite)
      else $error("untagged packet stripped");
endmodule : essb_chk
bind essb_top essb_chk essb_chk_i (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_q_nonempty(i_q_nonempty), .i_tx_req(i_tx_req),
   .o_grant_vld(o_grant_vld), .o_grant_q(o_grant_q), .o_q_blocked(o_q_blocked),
   .i_pkt(i_pkt), .o_tag(o_tag));
`default_nettype wire

// ### testbench/essb_mac_model.sv
// packet buffer and transmit mac model for the egress shaper
`timescale 1ns/10ps
`default_nettype none
module essb_mac_model (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // bench control
   input  wire logic [2:0]       i_req_en,
   // scheduler side
   input  wire logic [2:0]       i_grant_vld,
   input  wire logic [2:0][1:0]  i_grant_q,
   output logic      [11:0]      o_q_nonempty,
   output logic [11:0][10:0]     o_q_head_len,
   output logic      [2:0]       o_tx_req
);
   int          cnt [12] = '{default: 0};
   logic [10:0] len [12];
   int          busy [3] = '{default: 0};
   task automatic add(input int b, input int n, input logic [10:0] l);
      cnt[b] = cnt[b] + n;
      len[b] = l;
   endtask : add
   // packets wait in memory until granted
   always @(posedge i_clk) begin
      for (int p = 0; p < 3; p++) begin
         if (i_rst) busy[p] <= 0;
         else if (i_grant_vld[p]) begin
            cnt[p*4+i_grant_q[p]] <= cnt[p*4+i_grant_q[p]] - 1;
            busy[p] <= 3;
         end else if (busy[p] > 0) busy[p] <= busy[p] - 1;
      end
   end
   // empty queue shows no stale length
   always_comb begin
      for (int b = 0; b < 12; b++) begin
         o_q_nonempty[b] = cnt[b] != 0;
         o_q_head_len[b] = (cnt[b] != 0) ? len[b] : ~len[b];
      end
      for (int p = 0; p < 3; p++) o_tx_req[p] = i_req_en[p] && busy[p] == 0;
   end
endmodule : essb_mac_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the egress shaper and vlan tagger
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic                 i_clk = 1'b0;
   logic                 i_rst = 1'b1;
   logic [7:0]           adr = 8'h00;
   logic                 rd = 1'b0;
   logic                 wr = 1'b0;
   logic [31:0]          wd = 32'h0;
   logic [31:0]          rdata;
   logic                 wreq;
   logic [11:0]          nonempty;
   logic [11:0][10:0]    head_len;
   logic [2:0]           tx_req;
   logic [2:0]           req_en = 3'h0;
   logic [2:0]           p10m = 3'h0;
   logic [2:0]           gvld;
   logic [2:0][1:0]      gq;
   logic [11:0]          blk;
   essb_pkg::essb_pkt_t  pkt = '0;
   essb_pkg::essb_tag_t  tag;
   essb_pkg::essb_drop_t drop = '0;
   logic                 irq;
   logic [31:0]          rv;
   int                   mismatches = 0;
   int                   cmp_count = 0;
   int                   n;
   essb_top essb_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_q_nonempty(nonempty), .i_q_head_len(head_len),
      .i_tx_req(tx_req), .i_port_10m(p10m), .o_grant_vld(gvld), .o_grant_q(gq),
      .o_q_blocked(blk), .i_pkt(pkt), .o_tag(tag), .i_drop(drop), .o_irq(irq));
   essb_mac_model essb_mac_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_req_en(req_en),
      .i_grant_vld(gvld), .i_grant_q(gq), .o_q_nonempty(nonempty), .o_q_head_len(head_len),
      .o_tx_req(tx_req));
   initial forever #2.5 i_clk = ~i_clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      for (k = 0; k < 20; k++) begin
         @(posedge i_clk);
         if (!wreq) break;
      end
      if (k == 20) begin
         mismatches++;
         results();
      end
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), rv, e);
   endtask : rchk
   // f is strip, insert, special, rewrite, crc; u is vid then default un-tag bits
   task automatic tc(input logic [1:0] s, input logic [1:0] d, input logic [1:0] k,
                     input logic [5:0] u, input logic [4:0] f, input logic [14:0] ev);
      essb_pkg::essb_tag_t e;
      e = {1'b1, f, ev[11:0], ev[14:12]};
      @(posedge i_clk);
      pkt <= '{1'b1, s, d, essb_pkg::essb_rx_t'(k), 12'h0AB, 3'h4, u[5:3], u[2:0]};
      @(posedge i_clk);
      pkt <= '0;
      @(negedge i_clk);
      chk("tag", (f[3] | f[1]) ? tag : tag & 21'h1F8000, e);
   endtask : tc
   task automatic dr(input logic [1:0] s, input logic r);
      @(posedge i_clk);
      drop <= '{1'b1, s, r};
      @(posedge i_clk);
      drop <= '0;
   endtask : dr
   task automatic wg(input int p);
      int k;
      @(negedge i_clk);
      for (k = 0; k < 400 && !gvld[p]; k++) @(negedge i_clk);
      if (k == 400) begin
         mismatches++;
         results();
      end
   endtask : wg
   task automatic lim(input int b, input logic [12:0] s, input logic [10:0] l, input int e);
      int k;
      bus(1'b1, 8'h40 + 8'(4 * b), {19'h0, s});
      @(negedge i_clk);
      essb_mac_model_i.add(b, 1, l);
      wg(b / 4);
      n = 0;
      for (k = 0; k < 2000 && blk[b]; k++) begin
         n++;
         @(negedge i_clk);
      end
      chk("blocked cycles", n, e);
   endtask : lim
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      rchk(8'h00, 32'h0);
      rchk(8'h20, 32'h1);
      rchk(8'h44, 32'h0);
      rchk(8'h04, 32'h0);
      rchk(8'h0C, 32'h0);
      bus(1'b1, 8'h70, 32'hFFFFFFFF);
      rchk(8'h70, 32'h0);
      rchk(8'h21, 32'h0);
      bus(1'b1, 8'h20, 32'h5123);
      bus(1'b1, 8'h24, 32'h2456);
      bus(1'b1, 8'h28, 32'h6789);
      rchk(8'h28, 32'h6789);
      tc(2'h1, 2'h1, 2'h2, 6'h00, 5'h00, 15'h0);
      tc(2'h0, 2'h1, 2'h3, 6'h00, 5'h11, 15'h0);
      bus(1'b1, 8'h00, 32'h3E043);
      tc(2'h2, 2'h1, 2'h0, 6'h00, 5'h00, 15'h0);
      tc(2'h2, 2'h1, 2'h1, 6'h00, 5'h11, 15'h0);
      tc(2'h0, 2'h1, 2'h3, 6'h00, 5'h11, 15'h0);
      tc(2'h2, 2'h0, 2'h2, 6'h00, 5'h0D, 15'h4002);
      tc(2'h1, 2'h2, 2'h0, 6'h05, 5'h09, 15'h2456);
      tc(2'h1, 2'h2, 2'h0, 6'h02, 5'h00, 15'h0);
      tc(2'h0, 2'h2, 2'h1, 6'h00, 5'h03, 15'h5123);
      tc(2'h0, 2'h2, 2'h1, 6'h01, 5'h11, 15'h0);
      tc(2'h2, 2'h2, 2'h2, 6'h20, 5'h11, 15'h0);
      tc(2'h2, 2'h2, 2'h2, 6'h00, 5'h03, 15'h6789);
      tc(2'h0, 2'h2, 2'h3, 6'h00, 5'h11, 15'h0);
      bus(1'b1, 8'h00, 32'h36043);
      tc(2'h2, 2'h2, 2'h2, 6'h00, 5'h00, 15'h0);
      bus(1'b1, 8'h00, 32'h0E043);
      tc(2'h2, 2'h2, 2'h2, 6'h00, 5'h00, 15'h0);
      tc(2'h0, 2'h2, 2'h1, 6'h00, 5'h03, 15'h4123);
      dr(2'h1, 1'b0);
      dr(2'h1, 1'b1);
      dr(2'h2, 1'b1);
      dr(2'h1, 1'b0);
      bus(1'b1, 8'h84, 32'h0);
      rchk(8'h84, 32'h3);
      rchk(8'h94, 32'h1);
      rchk(8'h88, 32'h1);
      rchk(8'h98, 32'h1);
      rchk(8'h80, 32'h0);
      chk("irq", irq, 32'h0);
      bus(1'b1, 8'h0C, 32'h2);
      @(negedge i_clk);
      chk("irq", irq, 32'h1);
      rchk(8'h08, 32'h6);
      bus(1'b1, 8'h08, 32'h2);
      @(negedge i_clk);
      chk("irq", irq, 32'h0);
      rchk(8'h08, 32'h4);
      bus(1'b1, 8'h04, 32'h2C);
      rchk(8'h04, 32'h2C);
      req_en <= 3'h7;
      @(negedge i_clk);
      essb_mac_model_i.add(3, 2, 11'h004);
      essb_mac_model_i.add(0, 1, 11'h002);
      wg(0);
      chk("queue", gq[0], 32'h3);
      wg(0);
      chk("queue", gq[0], 32'h0);
      chk("held", blk[3], 32'h1);
      wg(0);
      chk("queue", gq[0], 32'h3);
      repeat (70) @(negedge i_clk);
      lim(3, 13'h0000, 11'h004, 64);
      lim(2, 13'h0005, 11'h003, 72);
      lim(1, 13'h0100, 11'h005, 0);
      p10m <= 3'h2;
      lim(5, 13'h0027, 11'h001, 160);
      lim(5, 13'h0028, 11'h001, 0);
      results();
   end
endmodule : tb
`default_nettype wire
